// >>> src/ocar_fifo.sv
// Small synchronous FIFO with valid and ready on both sides.
// Assumes a single clock, an active-low asynchronous reset and a clock enable.
`timescale 1ns/1ps
module ocar_fifo #(
  parameter int W = 12,
  parameter int D = 8
) (
  // Clock and reset.
  input  wire logic         ref_clk_i,
  input  wire logic         rstn_i,
  input  wire logic         clk_en_i,
  // Filling side.
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  // Draining side.
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int AW = $clog2(D);

  logic [W-1:0]  mem [D];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0]   count_r;
  logic          push;
  logic          pop;

  // Full and empty come straight from the occupancy count.
  assign in_ready_o  = (count_r != (AW+1)'(D));
  assign out_valid_o = (count_r != '0);
  assign push        = clk_en_i && in_valid_i && in_ready_o;
  assign pop         = clk_en_i && out_ready_i && out_valid_o;
  assign out_data_o  = mem[rd_ptr_r];

  // Storage array, written on each accepted word.
  always_ff @(posedge ref_clk_i)
  begin
    if (push)
    begin
      mem[wr_ptr_r] <= in_data_i;
    end
  end

  // Pointers and count.
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_r <= (wr_ptr_r == AW'(D-1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_r <= (rd_ptr_r == AW'(D-1)) ? '0 : rd_ptr_r + 1'b1;
      end
      if (push && !pop)
      begin
        count_r <= count_r + 1'b1;
      end
      else if (pop && !push)
      begin
        count_r <= count_r - 1'b1;
      end
    end
  end

endmodule

// >>> src/ocar_pkg.sv
// Constants and types for the OSD colour and attribute renderer.
// Assumes one pixel clock domain; no register bus, all controls are ports.
package ocar_pkg;

  // Widths of display words, colours and cells.
  localparam int WORD_W     = 12;
  localparam int COL_W      = 4;
  localparam int PAL_N      = 16;
  localparam int RGB_W      = 12;
  localparam int CELL_PIX   = 12;
  localparam int FIFO_DEPTH = 8;
  localparam logic [3:0] PIX_LAST = 4'hb;

  // Display word field positions.
  localparam int W_SERIAL   = 11;
  localparam int W_SMODE    = 10;
  localparam int W_EOR      = 9;
  localparam int W_BGDUR    = 8;
  localparam int W_BANK     = 7;
  localparam int W_BOX      = 6;
  localparam int W_OVER     = 5;
  localparam int W_UNDER    = 4;
  localparam int W_BG_LSB   = 0;
  localparam int W_FG_LSB   = 8;
  localparam int W_CODE_MSB = 7;

  // Palette field positions.
  localparam int PAL_R_LSB = 8;
  localparam int PAL_G_LSB = 4;
  localparam int PAL_B_LSB = 0;

  // Row defaults.
  localparam logic [3:0] BG_RESET  = 4'h8;
  localparam logic [2:0] FG_RESET  = 3'h0;
  localparam logic       BANK_RESET = 1'b0;

  // Font columns for graphic characters and their ordinary aliases.
  localparam logic [3:0] COL_GFX_LO = 4'h8;
  localparam logic [3:0] COL_GFX_HI = 4'h9;
  localparam logic [3:0] COL_ALT_LO = 4'hb;
  localparam logic [3:0] COL_ALT_HI = 4'hc;

  // Fixed in-bank colours of graphic planes 10 and 11.
  localparam logic [2:0] GFX_C2 = 3'h6;
  localparam logic [2:0] GFX_C3 = 3'h7;

  // Screen display modes {hi, lo}.
  typedef enum logic [1:0] {
    SCR_VIDEO = 2'b00,
    SCR_TEXT  = 2'b01,
    SCR_MIXS  = 2'b10,
    SCR_MIXV  = 2'b11
  } ocar_scr_t;

  // Row progress, Gray coded along idle, text, fill, done.
  typedef enum logic [1:0] {
    ROW_IDLE = 2'b00,
    ROW_TEXT = 2'b01,
    ROW_FILL = 2'b11,
    ROW_DONE = 2'b10
  } ocar_row_t;

endpackage

// >>> src/ocar_render.sv
// Pixel colour and attribute renderer of the on-screen display.
// Assumes timing strobes come from logic on ref_clk_i and the font ROM answers combinationally.
// Function
// R1: Sixteen palette entries of twelve bits, red high, green middle, blue low.
// R2: During fly-back RGB is all zeros, or all ones with inverted polarity.
// R3: Fast blank high for RGB, low for video; swapped when polarity select set.
// R4: Four-bit level scales each colour channel in sixteen steps.
// R5: Foreground colour comes from entries 0-7 or 8-15 by bank.
// R6: Bit 7 of a Mode 1 serial word switches the foreground bank.
// R7: Background colour may be any of the sixteen entries.
// R8: Mode 0 background applies at once; Mode 1 from next character.
// R9: Full text always shows background; mixed modes only inside boxes.
// R10: Mode 0 box and lines set at; later Mode 1 set after.
// R11: Mesh alternates background with video or screen colour, checkerboard per line.
// R12: Mesh applies to all background in full text, only boxes in mixed.
// R13: Background duration fills background to text end after end of row.
// R14: Underline forces bottom cell line to foreground, spaces too, duration extends it.
// R15: Overline forces top cell line to foreground, spaces too, duration extends it.
// R16: Graphic characters sit in columns 8, 9; even code, planes even/odd.
// R17: Planes map 00 bg, 01 fg, 10 colour 6/14, 11 colour 7/15.
// R18: Graphic characters are never fringed.
// R19: Unused graphic positions are reachable as ordinary characters via columns B, C.
// R20: In mixed mode, unboxed graphic background pixels show transparent video; the code shows screen colour instead in mixed screen mode.
// R21: Mode 1 end-of-row bit ends the row; text area bounds cap it.
// R22: Display words are read in sequence; total count bounded by memory.
// R23: Bit 11 marks serial, bit 10 selects mode, bits 0-3 background.
// R24: Parallel words carry code in bits 0-7, foreground in 8-10.
// R25: Screen mode bits: 00 video, 01 text, 10 mixed screen, 11 mixed video.
`timescale 1ns/1ps
module ocar_render (
  // Clock, reset and enable.
  input  wire logic                           ref_clk_i,
  input  wire logic                           rstn_i,
  input  wire logic                           clk_en_i,
  // Display word stream.
  input  wire logic                           word_valid_i,
  output logic                                word_ready_o,
  input  wire logic [ocar_pkg::WORD_W-1:0]    word_data_i,
  // Line and cell timing.
  input  wire logic                           flyback_i,
  input  wire logic                           row_start_i,
  input  wire logic                           text_active_i,
  input  wire logic                           cell_top_line_i,
  input  wire logic                           cell_bottom_line_i,
  input  wire logic                           line_odd_i,
  // Screen controls.
  input  wire logic                           screen_mode_sel_lo_i,
  input  wire logic                           screen_mode_sel_hi_i,
  input  wire logic [ocar_pkg::COL_W-1:0]     screen_colour_i,
  input  wire logic                           checker_bg_enable_i,
  input  wire logic                           blank_polarity_sel_i,
  input  wire logic [3:0]                     rgb_level_sel_i,
  // Palette write port.
  input  wire logic                           palette_wr_i,
  input  wire logic [ocar_pkg::COL_W-1:0]     palette_idx_i,
  input  wire logic [ocar_pkg::RGB_W-1:0]     palette_data_i,
  // Font ROM lookup.
  output logic [ocar_pkg::W_CODE_MSB:0]       font_code_lo_o,
  output logic [ocar_pkg::W_CODE_MSB:0]       font_code_hi_o,
  input  wire logic [ocar_pkg::CELL_PIX-1:0]  font_row_lo_i,
  input  wire logic [ocar_pkg::CELL_PIX-1:0]  font_row_hi_i,
  // Video outputs.
  output logic [3:0]                          red_o,
  output logic [3:0]                          green_o,
  output logic [3:0]                          blue_o,
  output logic                                fast_blank_out_o,
  output logic                                blank_invert_flag_o
);
  import ocar_pkg::*;

  // Scales one channel by the level; level 15 passes the value unchanged.
  function automatic logic [3:0] scale_ch(input logic [3:0] c, input logic [3:0] lvl);
    logic [7:0] p;
    p = {4'h0, c} * ({4'h0, lvl} + 8'h01);
    return p[7:4];
  endfunction

  // Picks the pixel of a font row, leftmost pixel first.
  function automatic logic row_bit(input logic [CELL_PIX-1:0] row, input logic [3:0] idx);
    logic [CELL_PIX-1:0] sh;
    sh = row << idx;
    return sh[CELL_PIX-1];
  endfunction

  // FIFO drain side.
  logic               fifo_valid;
  logic [WORD_W-1:0]  fifo_data;
  logic               fifo_pop;

  // Palette storage.
  logic [RGB_W-1:0]   palette_table [PAL_N];

  // Row state and cell tracking.
  ocar_row_t          row_state_r;
  ocar_row_t          row_state_nxt;
  logic [3:0]         pix_r;
  logic               cell_live_r;
  logic               first_pos_r;
  logic               eor_hit_r;
  logic               load_pt;

  // Live attributes and their next values.
  logic               fg_bank_r;
  logic               fg_bank_nxt;
  logic [COL_W-1:0]   bg_idx_r;
  logic [COL_W-1:0]   bg_idx_nxt;
  logic               under_r;
  logic               under_nxt;
  logic               over_r;
  logic               over_nxt;
  logic               box_r;
  logic               box_nxt;
  logic               bgdur_r;
  logic               bgdur_nxt;
  logic               eor_nxt;

  // Set-after attributes waiting for the next character.
  logic               pend_r;
  logic               pend_bank_r;
  logic [COL_W-1:0]   pend_bg_r;
  logic               pend_under_r;
  logic               pend_over_r;
  logic               pend_box_r;
  logic               pend_nxt;

  // Current cell contents.
  logic               cell_serial_r;
  logic               cell_gfx_r;
  logic [2:0]         cell_fg_r;

  // Pixel composition.
  ocar_scr_t          scr_mode;
  logic [COL_W-1:0]   fg_full;
  logic [COL_W-1:0]   pix_idx;
  logic               pix_video;
  logic               is_fg;
  logic               is_bg;
  logic [COL_W-1:0]   fg_sel;
  logic               in_cell;
  logic               in_fill;
  logic               mesh_hole;
  logic               bg_show;
  logic [RGB_W-1:0]   pal_rgb;

  // Incoming words are buffered ahead of the pixel path.
  ocar_fifo #(
    .W (WORD_W),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_i   (ref_clk_i),
    .rstn_i      (rstn_i),
    .clk_en_i    (clk_en_i),
    .in_valid_i  (word_valid_i),
    .in_ready_o  (word_ready_o),
    .in_data_i   (word_data_i),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_pop),
    .out_data_o  (fifo_data)
  );

  // A new cell starts when text begins or the previous cell ends.
  assign load_pt  = text_active_i && (row_state_r == ROW_TEXT) &&
                    (!cell_live_r || (pix_r == PIX_LAST));
  assign fifo_pop = load_pt && !eor_hit_r;  // see R22
  assign scr_mode = ocar_scr_t'({screen_mode_sel_hi_i, screen_mode_sel_lo_i});  // see R25

  // Palette writes.
  always_ff @(posedge ref_clk_i)
  begin
    if (clk_en_i && palette_wr_i)
    begin
      palette_table[palette_idx_i] <= palette_data_i;  // see R1
    end
  end

  // Row progress: text, then fill or done after end of row or text area end.
  always_comb
  begin
    row_state_nxt = row_state_r;
    case (row_state_r)
      ROW_IDLE: row_state_nxt = ROW_IDLE;
      ROW_TEXT:
      begin
        if (load_pt && eor_hit_r)
        begin
          row_state_nxt = bgdur_r ? ROW_FILL : ROW_DONE;  // see R13, R21
        end
        else if (cell_live_r && !text_active_i)
        begin
          row_state_nxt = ROW_DONE;  // see R21
        end
      end
      ROW_FILL:
      begin
        if (!text_active_i)
        begin
          row_state_nxt = ROW_DONE;  // see R13
        end
      end
      ROW_DONE: row_state_nxt = ROW_DONE;
      default:  row_state_nxt = ROW_IDLE;
    endcase
    if (row_start_i)
    begin
      row_state_nxt = ROW_TEXT;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      row_state_r <= ROW_IDLE;
    end
    else if (clk_en_i)
    begin
      row_state_r <= row_state_nxt;
    end
  end

  // Pixel counter inside a cell; it keeps running during the fill for the mesh.
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      pix_r       <= 4'h0;
      cell_live_r <= 1'b0;
      first_pos_r <= 1'b1;
    end
    else if (clk_en_i)
    begin
      if (row_start_i)
      begin
        pix_r       <= 4'h0;
        cell_live_r <= 1'b0;
        first_pos_r <= 1'b1;
      end
      else if (load_pt)
      begin
        pix_r       <= 4'h0;
        cell_live_r <= !eor_hit_r;
        first_pos_r <= 1'b0;
      end
      else if (cell_live_r || row_state_r == ROW_FILL)
      begin
        pix_r <= (pix_r == PIX_LAST) ? 4'h0 : pix_r + 4'h1;
      end
    end
  end

  // Decodes a new word into the next attribute values.
  always_comb
  begin
    fg_bank_nxt = pend_r ? pend_bank_r : fg_bank_r;  // see R8, R10
    bg_idx_nxt  = pend_r ? pend_bg_r : bg_idx_r;
    under_nxt   = pend_r ? pend_under_r : under_r;
    over_nxt    = pend_r ? pend_over_r : over_r;
    box_nxt     = pend_r ? pend_box_r : box_r;
    bgdur_nxt   = bgdur_r;
    eor_nxt     = 1'b0;
    pend_nxt    = 1'b0;
    if (fifo_valid && fifo_data[W_SERIAL])  // see R23
    begin
      if (!fifo_data[W_SMODE])
      begin
        bg_idx_nxt = fifo_data[W_BG_LSB +: COL_W];  // see R7, R8
        under_nxt  = fifo_data[W_UNDER];  // see R10, R14
        over_nxt   = fifo_data[W_OVER];  // see R15
        box_nxt    = fifo_data[W_BOX];
      end
      else
      begin
        bgdur_nxt = fifo_data[W_BGDUR];
        eor_nxt   = fifo_data[W_EOR];  // see R21
        if (first_pos_r)
        begin
          bg_idx_nxt  = fifo_data[W_BG_LSB +: COL_W];
          box_nxt     = fifo_data[W_BOX];
          fg_bank_nxt = fifo_data[W_BANK];  // see R6
        end
        else
        begin
          pend_nxt = 1'b1;  // see R8, R10
        end
      end
    end
  end

  // Attribute registers, restored to row defaults at each row start.
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      fg_bank_r <= BANK_RESET;
      bg_idx_r  <= BG_RESET;
      under_r   <= 1'b0;
      over_r    <= 1'b0;
      box_r     <= 1'b0;
      bgdur_r   <= 1'b0;
      eor_hit_r <= 1'b0;
    end
    else if (clk_en_i)
    begin
      if (row_start_i)
      begin
        fg_bank_r <= BANK_RESET;
        bg_idx_r  <= BG_RESET;
        under_r   <= 1'b0;
        over_r    <= 1'b0;
        box_r     <= 1'b0;
        bgdur_r   <= 1'b0;
        eor_hit_r <= 1'b0;
      end
      else if (fifo_pop)
      begin
        fg_bank_r <= fg_bank_nxt;
        bg_idx_r  <= bg_idx_nxt;
        under_r   <= under_nxt;
        over_r    <= over_nxt;
        box_r     <= box_nxt;
        bgdur_r   <= bgdur_nxt;
        eor_hit_r <= eor_nxt;
      end
    end
  end

  // Set-after values held until the following character loads.
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      pend_r       <= 1'b0;
      pend_bank_r  <= BANK_RESET;
      pend_bg_r    <= BG_RESET;
      pend_under_r <= 1'b0;
      pend_over_r  <= 1'b0;
      pend_box_r   <= 1'b0;
    end
    else if (clk_en_i)
    begin
      if (row_start_i)
      begin
        pend_r <= 1'b0;
      end
      else if (fifo_pop)
      begin
        pend_r       <= pend_nxt;
        pend_bank_r  <= fifo_data[W_BANK];  // see R6
        pend_bg_r    <= fifo_data[W_BG_LSB +: COL_W];
        pend_under_r <= fifo_data[W_UNDER];
        pend_over_r  <= fifo_data[W_OVER];
        pend_box_r   <= fifo_data[W_BOX];
      end
    end
  end

  // Cell contents and font addresses; an empty FIFO yields a blank space.
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cell_serial_r  <= 1'b1;
      cell_gfx_r     <= 1'b0;
      cell_fg_r      <= FG_RESET;
      font_code_lo_o <= '0;
      font_code_hi_o <= '0;
    end
    else if (clk_en_i && load_pt)
    begin
      cell_serial_r <= !(fifo_valid && !eor_hit_r) || fifo_data[W_SERIAL];
      cell_fg_r     <= fifo_data[W_FG_LSB +: 3];  // see R24
      cell_gfx_r    <= 1'b0;
      font_code_lo_o <= fifo_data[W_CODE_MSB:0];
      font_code_hi_o <= fifo_data[W_CODE_MSB:0];
      if (fifo_data[7:4] == COL_GFX_LO || fifo_data[7:4] == COL_GFX_HI)
      begin
        cell_gfx_r     <= !fifo_data[0];  // see R16
        font_code_hi_o <= {fifo_data[7:1], 1'b1};  // see R16
      end
      else if (fifo_data[7:4] == COL_ALT_LO)
      begin
        font_code_lo_o <= {COL_GFX_LO, fifo_data[3:0]};  // see R19
        font_code_hi_o <= {COL_GFX_LO, fifo_data[3:0]};
      end
      else if (fifo_data[7:4] == COL_ALT_HI)
      begin
        font_code_lo_o <= {COL_GFX_HI, fifo_data[3:0]};  // see R19
        font_code_hi_o <= {COL_GFX_HI, fifo_data[3:0]};
      end
    end
  end

  // Classifies the pixel as foreground, background or uncovered.
  always_comb
  begin
    fg_full = {fg_bank_r, cell_fg_r};  // see R5
    in_cell = (row_state_r == ROW_TEXT) && cell_live_r;
    in_fill = (row_state_r == ROW_FILL) && text_active_i;
    is_fg   = 1'b0;
    is_bg   = 1'b0;
    fg_sel  = fg_full;
    if (in_cell || in_fill)
    begin
      is_bg = 1'b1;
      if ((under_r && cell_bottom_line_i) || (over_r && cell_top_line_i))
      begin
        is_fg = 1'b1;  // see R14, R15
      end
      else if (in_cell && !cell_serial_r && cell_gfx_r)
      begin
        // Graphic cells use plane colours directly and bypass any edge effect.
        case ({row_bit(font_row_hi_i, pix_r), row_bit(font_row_lo_i, pix_r)})
          2'b01:   is_fg = 1'b1;  // see R17, R18
          2'b10:
          begin
            is_fg  = 1'b1;
            fg_sel = {fg_bank_r, GFX_C2};  // see R17
          end
          2'b11:
          begin
            is_fg  = 1'b1;
            fg_sel = {fg_bank_r, GFX_C3};  // see R17
          end
          default: is_fg = 1'b0;
        endcase
      end
      else if (in_cell && !cell_serial_r)
      begin
        is_fg = row_bit(font_row_lo_i, pix_r);
      end
    end
    mesh_hole = checker_bg_enable_i && (pix_r[0] ^ line_odd_i);  // see R11
    bg_show   = is_bg && !mesh_hole &&
                ((scr_mode == SCR_TEXT) || box_r);  // see R9, R12, R20
  end

  // Chooses the palette entry or video for the pixel.
  always_comb
  begin
    pix_video = 1'b0;
    pix_idx   = screen_colour_i;
    if (is_fg)
    begin
      pix_idx = fg_sel;
    end
    else if (bg_show)
    begin
      pix_idx = bg_idx_r;
    end
    else if (scr_mode == SCR_MIXV || scr_mode == SCR_VIDEO)
    begin
      pix_video = 1'b1;  // see R20
    end
    pal_rgb = palette_table[pix_idx];
  end

  // Output stage: blanking, polarity and brightness.
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      red_o               <= 4'h0;
      green_o             <= 4'h0;
      blue_o              <= 4'h0;
      fast_blank_out_o    <= 1'b0;
      blank_invert_flag_o <= 1'b0;
    end
    else if (clk_en_i)
    begin
      blank_invert_flag_o <= blank_polarity_sel_i;
      if (flyback_i)
      begin
        red_o            <= {4{blank_polarity_sel_i}};  // see R2
        green_o          <= {4{blank_polarity_sel_i}};
        blue_o           <= {4{blank_polarity_sel_i}};
        fast_blank_out_o <= blank_polarity_sel_i;  // see R3
      end
      else if (scr_mode == SCR_VIDEO || pix_video)
      begin
        red_o            <= 4'h0;
        green_o          <= 4'h0;
        blue_o           <= 4'h0;
        fast_blank_out_o <= blank_polarity_sel_i;  // see R3
      end
      else
      begin
        red_o            <= scale_ch(pal_rgb[PAL_R_LSB +: 4], rgb_level_sel_i);  // see R4
        green_o          <= scale_ch(pal_rgb[PAL_G_LSB +: 4], rgb_level_sel_i);
        blue_o           <= scale_ch(pal_rgb[PAL_B_LSB +: 4], rgb_level_sel_i);
        fast_blank_out_o <= !blank_polarity_sel_i;  // see R3
      end
    end
  end

endmodule

// >>> tb/ocar_render_chk.sv
// Output-stage checks for the OSD colour renderer.
// Assumes it is bound to ocar_render and sees only that module's ports.
`timescale 1ns/1ps
module ocar_render_chk (
  // Clock and reset.
  input wire logic       ref_clk_i,
  input wire logic       rstn_i,
  input wire logic       clk_en_i,
  // Controls.
  input wire logic       flyback_i,
  input wire logic       text_active_i,
  input wire logic       screen_mode_sel_lo_i,
  input wire logic       screen_mode_sel_hi_i,
  input wire logic       blank_polarity_sel_i,
  input wire logic [3:0] rgb_level_sel_i,
  // Video outputs.
  input wire logic [3:0] red_o,
  input wire logic [3:0] green_o,
  input wire logic [3:0] blue_o,
  input wire logic       fast_blank_out_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  logic [1:0]  md;
  logic [11:0] rgb;
  logic        on;
  // Mode word, joined levels and an enabled edge outside fly-back.
  assign md  = {screen_mode_sel_hi_i, screen_mode_sel_lo_i};
  assign rgb = {red_o, green_o, blue_o};
  assign on  = clk_en_i && !flyback_i;
  property p_fly_rgb;
    clk_en_i && flyback_i |=> rgb == {12{$past(blank_polarity_sel_i)}};
  endproperty
  a_fly_rgb: assert property (p_fly_rgb) else $error("fly-back levels wrong");
  property p_fly_fbl;
    clk_en_i && flyback_i |=> fast_blank_out_o == $past(blank_polarity_sel_i);
  endproperty
  a_fly_fbl: assert property (p_fly_fbl) else $error("fly-back blank wrong");
  property p_video;
    on && md == 2'b00 |=> rgb == 12'h000 && fast_blank_out_o == $past(blank_polarity_sel_i);
  endproperty
  a_video: assert property (p_video) else $error("video mode output wrong");
  property p_text_fbl;
    on && md inside {2'b01, 2'b10} |=> fast_blank_out_o != $past(blank_polarity_sel_i);
  endproperty
  a_text_fbl: assert property (p_text_fbl) else $error("text blank wrong");
  property p_mixv;
    on && md == 2'b11 && !text_active_i && !$past(text_active_i)
      |=> rgb == 12'h000 && fast_blank_out_o == $past(blank_polarity_sel_i);
  endproperty
  a_mixv: assert property (p_mixv) else $error("mixed video not video");
  property p_lvl0;
    on && rgb_level_sel_i == 4'h0 |=> rgb == 12'h000;
  endproperty
  a_lvl0: assert property (p_lvl0) else $error("lowest level not zero");
  property p_lvl_half;
    on && !rgb_level_sel_i[3] |=> !red_o[3] && !green_o[3] && !blue_o[3];
  endproperty
  a_lvl_half: assert property (p_lvl_half) else $error("level scale too high");
  property p_fly_hold;
    (clk_en_i && flyback_i) [*2] |=> $stable(rgb) ||
      $past(blank_polarity_sel_i) != $past(blank_polarity_sel_i, 2);
  endproperty
  a_fly_hold: assert property (p_fly_hold) else $error("fly-back level moved");
endmodule
bind ocar_render ocar_render_chk u_chk (.*);

// >>> tb/ocar_tv_sink.sv
// Behavioural video stage that receives the renderer's RGB and blanking.
// Assumes levels settle within one pixel; it decodes what the screen shows.
`timescale 1ns/1ps
module ocar_tv_sink (
  // Renderer outputs.
  input  wire logic [3:0] red_i,
  input  wire logic [3:0] green_i,
  input  wire logic [3:0] blue_i,
  input  wire logic       fast_blank_i,
  input  wire logic       invert_i,
  // Decoded picture.
  output logic [12:0]     pix_o,
  output logic            rgb_shown_o
);
  // RGB is shown when the blank level differs from the polarity flag.
  assign rgb_shown_o = fast_blank_i ^ invert_i;
  // Captured levels handed to the bench monitor.
  assign pix_o = {fast_blank_i, red_i, green_i, blue_i};
endmodule

// >>> tb/tb.sv
// Self-checking bench of the OSD renderer with a video sink and a font stub.
// Assumes the package, design, sink and checker are compiled before it.
`timescale 1ns/1ps
module tb;
  import ocar_pkg::*;
  logic        clk, rstn, vld, rdy, fly, rs, ta, top, bot, lodd, ml, mh, pol, pw, checker_bg_enable, fast_blank_out, inv;
  logic [11:0] wd, pd, fl, pal [16];
  logic [3:0]  scr, lvl, pi, red, grn, blu;
  logic [7:0]  fcl;
  logic [12:0] pix, qv[$];
  int          cyc, qt[$], cc[6], error_cnt, num_checks;
  logic [11:0] ws [9] = '{12'hc83, 12'h241, 12'h805, 12'h442, 12'he00,
                          12'h010, 12'h020, 12'h030, 12'h0ff};
  // Font stub: only the two letter codes have lit pixels.
  assign fl = (fcl == 8'h41 || fcl == 8'h42) ? 12'hfff : 12'h000;
  ocar_render DUT (
    .ref_clk_i(clk), .rstn_i(rstn), .clk_en_i(1'b1), .word_valid_i(vld),
    .word_ready_o(rdy), .word_data_i(wd), .flyback_i(fly), .row_start_i(rs),
    .text_active_i(ta), .cell_top_line_i(top), .cell_bottom_line_i(bot),
    .line_odd_i(lodd), .screen_mode_sel_lo_i(ml), .screen_mode_sel_hi_i(mh),
    .screen_colour_i(scr), .checker_bg_enable_i(checker_bg_enable), .blank_polarity_sel_i(pol),
    .rgb_level_sel_i(lvl), .palette_wr_i(pw), .palette_idx_i(pi), .palette_data_i(pd),
    .font_code_lo_o(fcl), .font_code_hi_o(), .font_row_lo_i(fl), .font_row_hi_i(12'h000),
    .red_o(red), .green_o(grn), .blue_o(blu), .fast_blank_out_o(fast_blank_out),
    .blank_invert_flag_o(inv));
  ocar_tv_sink u_sink (.red_i(red), .green_i(grn), .blue_i(blu), .fast_blank_i(fast_blank_out),
    .invert_i(inv), .pix_o(pix), .rgb_shown_o());
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Comparison and note helpers.
  task automatic chk(logic [12:0] s, logic [12:0] e);
    num_checks++;
    if (s !== e)
    begin
      error_cnt++;
      $display("mismatch t=%0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic nt(int d, logic [12:0] v);
    qt.push_back(cyc + d);
    qv.push_back(v);
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic pwr(int i, logic [11:0] d);
    @(posedge clk);
    {pw, pi, pd} <= {1'b1, 4'(i), d};
    pal[i] = d;
    @(posedge clk);
    pw <= 1'b0;
  endtask
  function automatic logic [3:0] sc(logic [3:0] c);
    return 4'((8'(c) * (8'(lvl) + 8'h01)) >> 4);
  endfunction
  function automatic logic [12:0] ex(logic f, logic [11:0] c);
    return {f, sc(c[11:8]), sc(c[7:4]), sc(c[3:0])};
  endfunction
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Monitor: the oldest note is compared when its cycle comes round.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (qt.size() > 0 && qt[0] == cyc)
    begin
      chk(pix, qv[0]);
      void'(qt.pop_front());
      void'(qv.pop_front());
    end
  end
  // Watchdog sized well past the few hundred cycles the tests need.
  initial
  begin
    #20000;
    error_cnt++;
    report_and_stop();
  end
  // Main sequence.
  initial
  begin
    {rstn, vld, fly, rs, ta, top, bot, lodd, ml, mh, pol, pw, checker_bg_enable} = '0;
    {wd, pd, scr, lvl, pi} = '0;
    void'($urandom(50));
    tick(5);
    rstn <= 1'b1;
    for (int i = 0; i < 16; i++) pwr(i, 12'($urandom));
    for (int p = 0; p < 2; p++)
    begin
      @(posedge clk);
      {pol, fly, lvl, mh, ml, top, bot, lodd} <= {p[0], 1'b1, 9'($urandom)};
      nt(3, {13{p[0]}});
      tick(4);
      chk(13'(inv), 13'(p[0]));
      {fly, mh, ml} <= 3'b000;
      nt(3, {p[0], 12'h000});
      tick(4);
    end
    $display("fly-back and video test done");
    for (int i = 0; i < 16; i++)
    begin
      @(posedge clk);
      {pol, lvl, scr, mh, ml} <= {i[3], 4'(i), 4'(15 - i), 2'(1 + i % 3)};
      @(posedge clk);
      nt(2, (i % 3 == 2) ? {pol, 12'h000} : ex(!pol, pal[scr]));
      tick(3);
    end
    $display("screen colour test done");
    {pol, lvl, mh, ml} <= {1'b0, 4'hf, 2'b01};
    for (int k = 0; k < 9; k++)
    begin
      @(posedge clk);
      {vld, wd} <= {1'b1, ws[k]};
    end
    @(posedge clk);
    @(negedge clk);
    chk(13'(rdy), 13'h0);
    cc = '{3, 10, 5, 12, 5, int'(scr)};
    @(posedge clk);
    rs <= 1'b1;
    foreach (cc[j])
      for (int k = 0; k < 12; k++)
        nt(4 + 12 * j + k, ex(1'b1, pal[cc[j]]));
    @(posedge clk);
    {rs, ta} <= 2'b01;
    tick(2);
    vld <= 1'b0;
    tick(78);
    ta <= 1'b0;
    @(negedge clk);
    chk(13'(rdy), 13'h1);
    tick(3);
    {rs, checker_bg_enable} <= 2'b11;
    for (int k = 0; k < 56; k++)
      nt(4 + k, ex(1'b1, pal[(k[0] ^ lodd) ? scr : BG_RESET]));
    @(posedge clk);
    {rs, ta} <= 2'b01;
    tick(60);
    ta <= 1'b0;
    tick(3);
    chk(13'(qt.size()), 13'h0);
    $display("row render test done");
    report_and_stop();
  end
endmodule
